// ### logic/csp_pkg.sv
// constants, bus carriers and field layout of the standard pwm channel
package csp_pkg;

	// clocking: the timers count the core clock divided by four
	localparam int CORE_CLK_HZ = 20_000_000;
	localparam int TIMER_CLK_HZ = 5_000_000;
	localparam int QTR_DIV = CORE_CLK_HZ / TIMER_CLK_HZ;
	localparam logic [1:0] QTR_LAST = 2'(QTR_DIV - 1);
	localparam int N_TIMERS = 3;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DUTY_LO = 8'h04;
	localparam logic [7:0] OFS_DUTY_HI = 8'h08;
	localparam logic [7:0] OFS_TSEL = 8'h0c;
	localparam logic [7:0] OFS_PIN = 8'h10;
	localparam logic [7:0] OFS_TCTL0 = 8'h14;
	localparam logic [7:0] OFS_PER0 = 8'h20;
	localparam logic [7:0] OFS_CNT0 = 8'h2c;
	localparam logic [7:0] OFS_FLAGS = 8'h38;
	localparam int OFS_STEP = 4;

	// channel_control fields
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_OUT_BIT = 5;
	localparam int CTRL_FMT_BIT = 4;
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_PWM = 4'hf;

	// timer_control fields
	localparam int TCTL_RUN_BIT = 2;

	// reset values
	localparam logic [1:0] TSEL_RST = 2'h1;
	localparam logic [1:0] TSEL_NONE = 2'h0;
	localparam logic PIN_DIR_RST = 1'b1;
	localparam logic [7:0] PER_RST = 8'hff;

	// timer prescale select
	typedef enum logic [1:0] {PS_1, PS_4, PS_16, PS_64} csp_psc_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} csp_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} csp_apb_rsp_t;

endpackage : csp_pkg

// ### logic/csp_pwm.sv
// standard pwm channel with three selectable 8-bit time bases and apb registers
// How it works
// - pwm output with up to ten-bit resolution
// - channel picks one of three 8-bit timers
// - period is (period+1) x 4 x prescale clocks
// - counter equals period: clear counter, set output
// - zero duty keeps output low at rollover
// - rollover copies duty into hidden 10-bit buffer
// - postscaler never affects the pwm period
// - duty is 10 bits across the byte pair
// - alignment bit picks left or right placement
// - duty writes take effect after next rollover
// - time base = counter plus two fraction bits
// - time base equals buffered duty: clear output
// - duty beyond period leaves output unchanged
// - resolution log2(4(period+1)), full at 255
// - sleep freezes counter and output level
// - mode 1111 is pwm, 0000 resets channel
// - status bit shows current output level
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module csp_pwm #(
	parameter int N_TMR = csp_pkg::N_TIMERS
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// register bus
	input wire csp_pkg::csp_apb_req_t i_apb,
	output csp_pkg::csp_apb_rsp_t o_apb,
	// power state
	input wire logic i_sleep,
	// channel output
	output logic o_pin_out,
	output logic o_pin_oe,
	output logic o_periph_out
);
	import csp_pkg::*;

	function automatic logic [7:0] reg_ofs(input logic [7:0] base, input int idx);
		reg_ofs = 8'(int'(base) + idx * OFS_STEP);
	endfunction : reg_ofs

	function automatic logic [5:0] psc_last(input logic [1:0] sel);
		case (sel)
			PS_1: psc_last = 6'h00;
			PS_4: psc_last = 6'h03;
			PS_16: psc_last = 6'h0f;
			default: psc_last = 6'h3f;
		endcase
	endfunction : psc_last

	csp_apb_rsp_t rsp_r;
	logic [1:0] qtr_r;
	logic en_r;
	logic fmt_r;
	logic [3:0] mode_r;
	logic [7:0] duty_lo_r;
	logic [7:0] duty_hi_r;
	logic [1:0] tsel_r;
	logic pin_dir_r;
	logic pin_oe_r;
	logic out_r;
	logic [9:0] duty_buf_r;
	logic run_r [N_TMR];
	logic [1:0] psc_sel_r [N_TMR];
	logic [7:0] per_r [N_TMR];
	logic [7:0] cnt_r [N_TMR];
	logic [5:0] pcnt_r [N_TMR];
	logic [N_TMR-1:0] flag_r;
	logic [N_TMR-1:0] roll;
	logic [N_TMR-1:0] step;
	logic [1:0] frac [N_TMR];
	logic qtick;
	logic acc;
	logic wr_en;
	logic rd_phase;
	logic addr_hit;
	logic [31:0] rd_data;
	logic active;
	logic [9:0] duty10;
	logic ch_roll;
	logic ch_step;
	logic duty_hit;
	logic [9:0] tb10;
	logic [7:0] ch_per;

	assign o_apb = rsp_r;
	assign o_pin_out = out_r;
	assign o_periph_out = out_r;
	assign o_pin_oe = pin_oe_r;

	// core/4 enable; the timers only see this tick
	assign qtick = (qtr_r == QTR_LAST) && !i_sleep;
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			qtr_r <= '0;
		end else if (!i_sleep) begin
			qtr_r <= 2'(qtr_r + 2'h1);
		end
	end

	// apb slave: one wait state, write lands on the edge that sees pready
	assign acc = i_apb.psel && i_apb.penable;
	assign rd_phase = acc && !rsp_r.pready;
	assign wr_en = acc && i_apb.pwrite && rsp_r.pready;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rsp_r <= '0;
		end else begin
			rsp_r.pready <= rd_phase;
			rsp_r.pslverr <= rd_phase && !addr_hit;
			if (rd_phase) begin
				rsp_r.prdata <= rd_data;
			end
		end
	end

	always_comb begin
		rd_data = '0;
		addr_hit = 1'b1;
		case (i_apb.paddr)
			OFS_CTRL: begin
				rd_data[CTRL_EN_BIT] = en_r;
				rd_data[CTRL_OUT_BIT] = out_r;
				rd_data[CTRL_FMT_BIT] = fmt_r;
				rd_data[3:0] = mode_r;
			end
			OFS_DUTY_LO: rd_data[7:0] = duty_lo_r;
			OFS_DUTY_HI: rd_data[7:0] = duty_hi_r;
			OFS_TSEL: rd_data[1:0] = tsel_r;
			OFS_PIN: rd_data[0] = pin_dir_r;
			OFS_FLAGS: rd_data[N_TMR-1:0] = flag_r;
			default: addr_hit = 1'b0;
		endcase
		for (int t = 0; t < N_TMR; t++) begin
			if (i_apb.paddr == reg_ofs(OFS_TCTL0, t)) begin
				rd_data[TCTL_RUN_BIT] = run_r[t];
				rd_data[1:0] = psc_sel_r[t];
				addr_hit = 1'b1;
			end
			if (i_apb.paddr == reg_ofs(OFS_PER0, t)) begin
				rd_data[7:0] = per_r[t];
				addr_hit = 1'b1;
			end
			if (i_apb.paddr == reg_ofs(OFS_CNT0, t)) begin
				rd_data[7:0] = cnt_r[t];
				addr_hit = 1'b1;
			end
		end
	end

	// channel configuration
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			en_r <= 1'b0;
			fmt_r <= 1'b0;
			mode_r <= MODE_OFF;
			duty_lo_r <= '0;
			duty_hi_r <= '0;
			tsel_r <= TSEL_RST;
			pin_dir_r <= PIN_DIR_RST;
		end else if (wr_en) begin
			case (i_apb.paddr)
				OFS_CTRL: begin
					en_r <= i_apb.pwdata[CTRL_EN_BIT];
					fmt_r <= i_apb.pwdata[CTRL_FMT_BIT];
					mode_r <= i_apb.pwdata[3:0];
				end
				OFS_DUTY_LO: duty_lo_r <= i_apb.pwdata[7:0];
				OFS_DUTY_HI: duty_hi_r <= i_apb.pwdata[7:0];
				OFS_TSEL: tsel_r <= i_apb.pwdata[1:0];
				OFS_PIN: pin_dir_r <= i_apb.pwdata[0];
				default: ;
			endcase
		end
	end

	// pin driver enabled while direction bit is clear
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pin_oe_r <= 1'b0;
		end else begin
			pin_oe_r <= !pin_dir_r;
		end
	end

	// three 8-bit auto-reload time bases
	for (genvar t = 0; t < N_TMR; t++) begin : g_tmr
		logic pre_last;
		logic inc;
		logic [5:0] frac_low;
		assign pre_last = (pcnt_r[t] == psc_last(psc_sel_r[t]));
		assign inc = qtick && run_r[t] && pre_last;
		assign roll[t] = inc && (cnt_r[t] == per_r[t]);
		// bits below the fraction wrap at the next lower setting's terminal count
		assign frac_low = psc_last(2'(psc_sel_r[t] - 2'h1));
		assign step[t] = run_r[t] && ((psc_sel_r[t] == PS_1) ? !i_sleep
			: qtick && ((pcnt_r[t] & frac_low) == frac_low));

		// fraction bits: core phase at 1:1, else the prescaler's top two bits
		always_comb begin
			case (psc_sel_r[t])
				PS_1: frac[t] = qtr_r;
				PS_4: frac[t] = pcnt_r[t][1:0];
				PS_16: frac[t] = pcnt_r[t][3:2];
				default: frac[t] = pcnt_r[t][5:4];
			endcase
		end

		always_ff @(posedge i_core_clk) begin
			if (!i_rst_n) begin
				run_r[t] <= 1'b0;
				psc_sel_r[t] <= PS_1;
				per_r[t] <= PER_RST;
			end else if (wr_en) begin
				if (i_apb.paddr == reg_ofs(OFS_TCTL0, t)) begin
					run_r[t] <= i_apb.pwdata[TCTL_RUN_BIT];
					psc_sel_r[t] <= i_apb.pwdata[1:0];
				end
				if (i_apb.paddr == reg_ofs(OFS_PER0, t)) begin
					per_r[t] <= i_apb.pwdata[7:0];
				end
			end
		end

		always_ff @(posedge i_core_clk) begin
			if (!i_rst_n) begin
				pcnt_r[t] <= '0;
			end else if (qtick && run_r[t]) begin
				pcnt_r[t] <= pre_last ? 6'h00 : 6'(pcnt_r[t] + 6'h01);
			end
		end

		// period depends on period register and prescale only
		always_ff @(posedge i_core_clk) begin
			if (!i_rst_n) begin
				cnt_r[t] <= '0;
			end else if (inc) begin
				cnt_r[t] <= roll[t] ? 8'h00 : 8'(cnt_r[t] + 8'h01);
			end
		end

		// match flag: write one to clear, a new match wins
		always_ff @(posedge i_core_clk) begin
			if (!i_rst_n) begin
				flag_r[t] <= 1'b0;
			end else if (roll[t]) begin
				flag_r[t] <= 1'b1;
			end else if (wr_en && i_apb.paddr == OFS_FLAGS && i_apb.pwdata[t]) begin
				flag_r[t] <= 1'b0;
			end
		end
	end

	// time base selection for the channel
	always_comb begin
		ch_roll = 1'b0;
		ch_step = 1'b0;
		tb10 = '0;
		ch_per = '0;
		for (int t = 0; t < N_TMR; t++) begin
			if (tsel_r != TSEL_NONE && int'(tsel_r) == t + 1) begin
				ch_roll = roll[t];
				ch_step = step[t];
				tb10 = {cnt_r[t], frac[t]};
				ch_per = per_r[t];
			end
		end
	end

	assign active = en_r && (mode_r == MODE_PWM);
	assign duty10 = fmt_r ? {duty_hi_r, duty_lo_r[7:6]} : {duty_hi_r[1:0], duty_lo_r};
	// clear as the time base steps onto the duty value, so the high time is duty steps
	assign duty_hit = ch_step && (10'(tb10 + 10'h001) == duty_buf_r);

	// hidden duty buffer, reloaded only at rollover
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || !active) begin
			duty_buf_r <= '0;
		end else if (ch_roll) begin
			duty_buf_r <= duty10;
		end
	end

	// output latch; a duty beyond the period never matches and leaves it as it is
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || !active) begin
			out_r <= 1'b0;
		end else if (ch_roll) begin
			out_r <= (duty10 != 10'h000);
		end else if (duty_hit) begin
			out_r <= 1'b0;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	a_apb_one_wait: assert property (rd_phase |=> rsp_r.pready && !$past(rsp_r.pready))
		else $error("apb answer not one cycle after access");
	a_roll_sets_out: assert property (active && ch_roll && duty10 != 10'h000 ##1 active |-> out_r)
		else $error("output not set at rollover");
	a_zero_duty_low: assert property (ch_roll && duty10 == 10'h000 |=> !out_r)
		else $error("zero duty drove output high");
	a_duty_latch: assert property (active && ch_roll ##1 active |-> duty_buf_r == $past(duty10))
		else $error("duty buffer not loaded at rollover");
	a_duty_hold: assert property (active && !ch_roll ##1 active |-> $stable(duty_buf_r))
		else $error("duty buffer changed between rollovers");
	a_match_clears: assert property (active && !ch_roll && duty_hit ##1 active |-> !out_r)
		else $error("output not cleared on duty match");
	a_long_duty_hold: assert property (active && !ch_roll && duty_buf_r > {ch_per, 2'h3}
		##1 active |-> $stable(out_r))
		else $error("output moved with duty beyond period");
	a_sleep_freeze: assert property (i_sleep |=> $stable(cnt_r[0]) && $stable(qtr_r))
		else $error("time base moved in sleep");
	a_mode_off: assert property (!active |=> !out_r && duty_buf_r == 10'h000)
		else $error("channel not reset while off");
	a_status_bit: assert property (rd_phase && i_apb.paddr == OFS_CTRL
		|=> rsp_r.prdata[CTRL_OUT_BIT] == $past(out_r))
		else $error("status bit does not show output");
	a_roll_at_period: assert property (roll[0] |=> cnt_r[0] == 8'h00 && flag_r[0])
		else $error("counter not cleared at period match");

	c_pulse_cycle: cover property (active && ch_roll && duty10 != 10'h000 ##[1:1000] !out_r);
	c_zero_duty: cover property (active && ch_roll && duty10 == 10'h000);
	c_sleep_hold: cover property (active && out_r && i_sleep [*4]);
	c_left_align: cover property (active && fmt_r && ch_roll);

endmodule : csp_pwm
`default_nettype wire

// ### tb/csp_load.sv
// load model: measures pwm period and high time seen on the pin
`timescale 1ns/10ps
`default_nettype none
module csp_load (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// pin drive
	input wire logic i_out,
	input wire logic i_oe,
	// measurements
	output logic [15:0] o_per,
	output logic [15:0] o_hi,
	output logic [15:0] o_rises
);
	logic pin;
	logic lvl_r;
	logic [15:0] cnt_r;
	logic [15:0] hcnt_r;
	// pin pulled down while the driver is off
	assign pin = i_oe ? i_out : 1'b0;
	always_ff @(posedge i_core_clk) begin
		lvl_r <= pin;
		cnt_r <= cnt_r + 16'h1;
		hcnt_r <= hcnt_r + {15'h0, pin};
		if (!i_rst_n) begin
			o_rises <= 16'h0;
			cnt_r <= 16'h0;
			hcnt_r <= 16'h0;
		end else if (pin && !lvl_r) begin
			o_per <= cnt_r;
			o_hi <= hcnt_r;
			o_rises <= o_rises + 16'h1;
			cnt_r <= 16'h1;
			hcnt_r <= 16'h1;
		end
	end
endmodule : csp_load
`default_nettype wire

// ### tb/csp_pwm_bench.sv
// self-checking bench for the standard pwm channel
`timescale 1ns/10ps
`default_nettype none
module csp_pwm_bench;
	import csp_pkg::*;
	logic core_clk;
	logic rst_n;
	logic sleep;
	csp_apb_req_t req;
	csp_apb_rsp_t rsp;
	logic pin_out;
	logic pin_oe;
	logic periph_out;
	logic [15:0] per;
	logic [15:0] hi;
	logic [15:0] rises;
	logic [31:0] rd;
	logic er;
	int err_count;
	int n_tests;

	csp_pwm u_dut (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_apb(req), .o_apb(rsp),
		.i_sleep(sleep), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_periph_out(periph_out));
	csp_load u_load (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_out(pin_out), .i_oe(pin_oe),
		.o_per(per), .o_hi(hi), .o_rises(rises));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic end_sim();
		if (err_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	// one apb transfer, entered and left just after a rising edge
	// no wait limit of its own: the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge core_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
		@(posedge core_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, m);
	endtask : rchk

	task automatic t_regs();
		rchk(OFS_CTRL, 32'h0, "ctrl");
		rchk(OFS_TSEL, {30'h0, TSEL_RST}, "tsel");
		rchk(OFS_PIN, {31'h0, PIN_DIR_RST}, "dir");
		rchk(OFS_PER0, {24'h0, PER_RST}, "per");
		apb(1'b1, 8'h3c, 32'h1);
		chk({31'h0, er}, 32'h1, "slverr");
	endtask : t_regs

	task automatic t_base();
		int n;
		n = 0;
		wr(OFS_PER0, 32'h1);
		wr(OFS_CTRL, 32'h8f);
		wr(OFS_DUTY_LO, 32'h4);
		wr(OFS_DUTY_HI, 32'h0);
		wr(OFS_FLAGS, 32'h7);
		wr(OFS_TCTL0, 32'h4);
		do begin
			apb(1'b0, OFS_FLAGS, 32'h0);
			n++;
		end while (rd[0] !== 1'b1 && n < 50);
		chk(rd & 32'h1, 32'h1, "flag");
		wr(OFS_PIN, 32'h0);
		cyc(30);
		chk({16'h0, per}, 2 * QTR_DIV, "period");
		chk({16'h0, hi}, 32'd4, "high");
		wr(OFS_CTRL, 32'h9f);
		wr(OFS_DUTY_HI, 32'h1);
		wr(OFS_DUTY_LO, 32'h40);
		cyc(30);
		chk({16'h0, hi}, 32'd5, "left");
	endtask : t_base

	task automatic t_edge();
		logic [15:0] r0;
		wr(OFS_DUTY_HI, 32'h0);
		wr(OFS_DUTY_LO, 32'h0);
		cyc(20);
		r0 = rises;
		cyc(40);
		chk({16'h0, rises}, {16'h0, r0}, "zero");
		chk({31'h0, pin_out}, 32'h0, "zlvl");
		wr(OFS_CTRL, 32'h8f);
		wr(OFS_DUTY_LO, 32'h9);
		cyc(20);
		r0 = rises;
		cyc(40);
		chk({16'h0, rises}, {16'h0, r0}, "over");
		rchk(OFS_CTRL, 32'haf, "status");
		wr(OFS_PIN, 32'h1);
		cyc(2);
		chk({30'h0, pin_oe, periph_out}, 32'h1, "periph");
		wr(OFS_PIN, 32'h0);
		wr(OFS_DUTY_LO, 32'h4);
		cyc(30);
		chk({16'h0, hi}, 32'd4, "buffer");
	endtask : t_edge

	task automatic t_sleep();
		logic [31:0] c0;
		logic l0;
		sleep <= 1'b1;
		cyc(2);
		apb(1'b0, OFS_CNT0, 32'h0);
		c0 = rd;
		l0 = pin_out;
		cyc(20);
		rchk(OFS_CNT0, c0, "frozen");
		chk({31'h0, pin_out}, {31'h0, l0}, "hold");
		sleep <= 1'b0;
		cyc(30);
		chk({16'h0, per}, 2 * QTR_DIV, "wake");
	endtask : t_sleep

	task automatic t_wide();
		wr(OFS_TSEL, 32'h2);
		wr(OFS_DUTY_HI, 32'h2);
		wr(OFS_DUTY_LO, 32'h5);
		wr(OFS_TCTL0 + 8'(OFS_STEP), 32'h5);
		cyc(3 * 4096 + 100);
		chk({16'h0, per}, 256 * QTR_DIV * 4, "wper");
		chk({16'h0, hi}, 517 * 4, "whigh");
		wr(OFS_CTRL, 32'h0);
		cyc(2);
		chk({31'h0, pin_out}, 32'h0, "off");
		rchk(OFS_CTRL, 32'h0, "offrd");
	endtask : t_wide

	task automatic t_psc();
		wr(OFS_CTRL, 32'h8f);
		wr(OFS_TSEL, 32'h3);
		wr(OFS_PER0 + 8'(2 * OFS_STEP), 32'h1);
		wr(OFS_DUTY_HI, 32'h0);
		wr(OFS_DUTY_LO, 32'h3);
		wr(OFS_TCTL0 + 8'(2 * OFS_STEP), 32'h6);
		cyc(3 * 128 + 40);
		chk({16'h0, per}, 2 * QTR_DIV * 16, "p16");
		chk({16'h0, hi}, 3 * 16, "h16");
		wr(OFS_TCTL0 + 8'(2 * OFS_STEP), 32'h7);
		cyc(3 * 512 + 40);
		chk({16'h0, per}, 2 * QTR_DIV * 64, "p64");
		chk({16'h0, hi}, 3 * 64, "h64");
	endtask : t_psc

	initial begin
		repeat (40000) @(posedge core_clk);
		err_count++;
		end_sim();
	end

	initial begin
		err_count = 0;
		n_tests = 0;
		rst_n = 1'b0;
		sleep = 1'b0;
		req = '0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_base();
		t_edge();
		t_sleep();
		t_wide();
		t_psc();
		end_sim();
	end
endmodule : csp_pwm_bench
`default_nettype wire
